//--- logic/uart_chan_cfg.svh
// Constants of one serial channel: register offsets, field positions,
// reset values, command codes and timing counts.
// Assumes a 100 MHz system clock standing in for the oscillator input.
`ifndef UART_CHAN_CFG_SVH
`define UART_CHAN_CFG_SVH

// Register offsets on the 6-bit address
`define UART_OFS_MODE 6'h00
`define UART_OFS_STATUS 6'h01
`define UART_OFS_COMMAND 6'h02
`define UART_OFS_HOLDING 6'h03
`define UART_OFS_INPUT_CHANGE 6'h04
`define UART_OFS_IRQ 6'h05
`define UART_OFS_TIMER 6'h06
`define UART_OFS_OUTPUT_CFG 6'h07
`define UART_OFS_INPUT_PORT 6'h08
`define UART_OFS_CLOCK_SEL 6'h09

// Field positions
`define UART_MR1_AUTO_RTS 7
`define UART_MR2_CTS_ENABLE 4
`define UART_MR2_LOCAL_LOOP 7
`define UART_CSEL_EXT_RX 0
`define UART_CSEL_EXT_TX 1
`define UART_ST_RX_READY 0
`define UART_ST_FIFO_FULL 1
`define UART_ST_TX_READY 2
`define UART_ST_TX_EMPTY 3
`define UART_ST_OVERRUN 4
`define UART_ST_FRAMING 6
`define UART_IRQ_TX_READY 0
`define UART_IRQ_RX_READY 1
`define UART_IRQ_TIMER 3
`define UART_IRQ_INPUT_CHANGE 7
`define UART_INPUT_CHANGE_REG_DELTA 4

// Command codes in the upper nibble
`define UART_CMD_RESET_POINTER 4'h1
`define UART_CMD_RESET_RX 4'h2
`define UART_CMD_RESET_TX 4'h3
`define UART_CMD_RESET_ERROR 4'h4
`define UART_CMD_ASSERT_RTS 4'h8
`define UART_CMD_NEGATE_RTS 4'h9
`define UART_CMD_POWER_DOWN 4'hc
`define UART_CMD_POWER_UP 4'hd

// Reset values
`define UART_RST_BYTE 8'h00
`define UART_RST_OUTPUT_CFG 3'h0

// Timing: oscillator rate and baud give the 16x divider
`define UART_OSC_HZ 100000000
`define UART_BAUD 115200
`define UART_BAUD_DIV (`UART_OSC_HZ / (16 * `UART_BAUD))
`define UART_FIFO_DEPTH 8

`endif

//--- logic/uart_chan_pkg.sv
// Types shared by the serial channel files.
// Assumes the constants header is included by the design files.
`default_nettype none
package uart_chan_pkg;

  // Receiver sequence, Gray coded along the frame
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b11,
    RX_STOP = 2'b10
  } rx_state_t;

  // Transmitter sequence, Gray coded along the frame
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_START = 2'b01,
    TX_DATA = 2'b11,
    TX_STOP = 2'b10
  } tx_state_t;

  // Functions of the multi-purpose output
  typedef enum logic [2:0] {
    MPO_RTS = 3'h0,
    MPO_TIMER = 3'h1,
    MPO_TX_1X = 3'h2,
    MPO_TX_16X = 3'h3,
    MPO_RX_1X = 3'h4,
    MPO_RX_16X = 3'h5,
    MPO_TX_READY = 3'h6,
    MPO_RX_FLAG = 3'h7
  } mpo_func_t;

endpackage : uart_chan_pkg

`default_nettype wire

//--- logic/rx_fifo.sv
// Receive FIFO with registered read data and show-ahead output.
// Assumes one clock; source and sink use valid/ready handshakes.
`timescale 1ns/1ns
`default_nettype none

module rx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_flush,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;

  // Handshake decode
  wire push = i_in_valid && (count != DEPTH[AW:0]);
  wire pop = i_out_ready && (count != '0);
  wire [AW-1:0] next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
  wire [AW:0] next_count = AW'(0) + count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  wire bypass = push && (wr_ptr == next_rd_ptr);

  assign o_in_ready = (count != DEPTH[AW:0]);
  assign o_out_valid = (count != '0);

  // Storage array
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // Pointers, fill level and registered head word
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      o_out_data <= '0;
    end else if (i_flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= push ? AW'(wr_ptr + 1'b1) : wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      o_out_data <= bypass ? i_in_data : mem[next_rd_ptr];
    end
  end
endmodule : rx_fifo

`default_nettype wire

//--- logic/uart_channel.sv
// One asynchronous serial channel behind an 8-bit strobe bus.
// Assumes all pins are asynchronous to i_clk_sys; host holds address
// and data steady for at least three clocks around each strobe edge.
`timescale 1ns/1ns
`default_nettype none
`include "uart_chan_cfg.svh"

module uart_channel #(
  parameter int BAUD_DIV = `UART_BAUD_DIV,
  parameter int FIFO_DEPTH = `UART_FIFO_DEPTH
) (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_master_reset,
  input wire logic i_chip_select_n,
  input wire logic i_write_strobe_n,
  input wire logic i_read_strobe_n,
  input wire logic [5:0] i_addr,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  output logic o_data_oe,
  input wire logic i_interrupt_request_n,
  output logic o_interrupt_request_n,
  output logic o_interrupt_request_n_oe,
  input wire logic i_serial_in,
  output logic o_serial_out,
  input wire logic i_ext_rx_clock,
  input wire logic i_ext_tx_clock,
  input wire logic i_multi_input_zero,
  output logic o_multi_output_pin
);
  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  localparam int NSYNC = 23;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  wire [NSYNC-1:0] pins = {i_master_reset, i_chip_select_n, i_write_strobe_n, i_read_strobe_n, i_addr, i_data,
    i_serial_in, i_ext_rx_clock, i_ext_tx_clock, i_multi_input_zero, i_interrupt_request_n};

  // Two flops on every pin before use
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync_a <= 23'h7f_ffff;
      sync_b <= 23'h7f_ffff;
    end else begin
      sync_a <= pins;
      sync_b <= sync_a;
    end
  end

  wire mreset = sync_b[22];
  wire cs_n = sync_b[21];
  wire wr_n = sync_b[20];
  wire rd_n = sync_b[19];
  wire [5:0] addr = sync_b[18:13];
  wire [7:0] wdata = sync_b[12:5];
  wire line_in = sync_b[4];
  wire ext_rx_clk = sync_b[3];
  wire ext_tx_clk = sync_b[2];
  wire mpi0 = sync_b[1];
  wire irq_wire = sync_b[0];

  logic wr_n_d;
  logic rd_n_d;
  logic ext_rx_d;
  logic ext_tx_d;
  logic mpi0_d;

  // Edge history of synchronised levels
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {wr_n_d, rd_n_d, ext_rx_d, ext_tx_d, mpi0_d} <= 5'h1f;
    end else begin
      {wr_n_d, rd_n_d, ext_rx_d, ext_tx_d, mpi0_d} <= {wr_n, rd_n, ext_rx_clk, ext_tx_clk, mpi0};
    end
  end

  // ****************************************************************
  // Host access decode
  // ****************************************************************
  wire wr_ev = !cs_n && wr_n && !wr_n_d;
  wire rd_ev = !cs_n && !rd_n && rd_n_d;
  wire wr_mode = wr_ev && (addr == `UART_OFS_MODE);
  wire wr_cmd = wr_ev && (addr == `UART_OFS_COMMAND);
  wire wr_hold = wr_ev && (addr == `UART_OFS_HOLDING);
  wire rd_hold = rd_ev && (addr == `UART_OFS_HOLDING);
  wire rd_input_change_reg = rd_ev && (addr == `UART_OFS_INPUT_CHANGE);
  wire [3:0] cmd = wdata[7:4];

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] mode_reg_one;
  logic [7:0] mode_reg_two;
  logic mode_ptr_two;
  logic [7:0] irq_mask_reg;
  logic [2:0] output_config_reg;
  logic [1:0] clock_select_reg;
  logic [7:0] timer_preset;
  logic rx_enable;
  logic tx_enable;
  logic rts_asserted;
  logic power_down;
  logic overrun;
  logic framing;
  logic input_delta;
  logic timer_run;
  logic timer_out;

  wire auto_rts = mode_reg_one[`UART_MR1_AUTO_RTS];
  wire cts_gate = mode_reg_two[`UART_MR2_CTS_ENABLE];
  wire local_loop = mode_reg_two[`UART_MR2_LOCAL_LOOP];
  wire ext_rx = clock_select_reg[`UART_CSEL_EXT_RX];
  wire ext_tx = clock_select_reg[`UART_CSEL_EXT_TX];

  // ****************************************************************
  // Baud generator and timer
  // ****************************************************************
  localparam int BW = $clog2(BAUD_DIV + 1);
  logic [BW-1:0] baud_cnt;
  logic [7:0] timer_cnt;
  wire baud_tick = !power_down && (baud_cnt == '0);
  wire clk16_level = (baud_cnt >= BW'(BAUD_DIV / 2));
  wire timer_zero = timer_run && baud_tick && (timer_cnt == 8'h00);

  // Oscillator-derived 16x tick and square-wave timer
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      baud_cnt <= '0;
      timer_cnt <= `UART_RST_BYTE;
      timer_out <= 1'b0;
    end else begin
      baud_cnt <= (baud_cnt == BW'(BAUD_DIV - 1)) ? '0 : BW'(baud_cnt + 1'b1);
      if (!timer_run || timer_zero) begin
        timer_cnt <= timer_preset;
      end else if (baud_tick) begin
        timer_cnt <= timer_cnt - 8'h01;
      end
      timer_out <= timer_run && (timer_out ^ timer_zero);
    end
  end

  // ****************************************************************
  // Transmitter
  // ****************************************************************
  uart_chan_pkg::tx_state_t tx_state;
  logic [3:0] tx_phase;
  logic [2:0] tx_bit;
  logic [7:0] tx_holding;
  logic tx_holding_full;
  logic [7:0] tx_shift;
  logic tx_line;
  wire tx_1x_level = !tx_phase[3];
  wire tx_fall = ext_tx ? (!ext_tx_clk && ext_tx_d) : (baud_tick && (tx_phase == 4'h7));
  wire cts_ok = !cts_gate || !mpi0;
  wire tx_idle = (tx_state == uart_chan_pkg::TX_IDLE);
  wire tx_done = tx_fall && (tx_state == uart_chan_pkg::TX_STOP);
  wire tx_load = tx_fall && tx_idle && tx_holding_full && tx_enable && cts_ok;
  wire tx_reset = mreset || (wr_cmd && cmd == `UART_CMD_RESET_TX);

  // Holding register and bit sequencer; new data only on falling edge
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_state <= uart_chan_pkg::TX_IDLE;
      tx_phase <= 4'h0;
      tx_bit <= 3'h0;
      tx_holding <= `UART_RST_BYTE;
      tx_holding_full <= 1'b0;
      tx_shift <= `UART_RST_BYTE;
      tx_line <= 1'b1;
    end else if (tx_reset) begin
      tx_state <= uart_chan_pkg::TX_IDLE;
      tx_holding_full <= 1'b0;
      tx_line <= 1'b1;
    end else begin
      tx_phase <= baud_tick ? tx_phase + 4'h1 : tx_phase;
      if (wr_hold && tx_enable) begin
        tx_holding <= wdata;
        tx_holding_full <= 1'b1;
      end else if (tx_load) begin
        tx_holding_full <= 1'b0;
      end
      if (tx_fall) begin
        case (tx_state)
          uart_chan_pkg::TX_IDLE: begin
            if (tx_load) begin
              tx_shift <= tx_holding;
              tx_line <= 1'b0;
              tx_state <= uart_chan_pkg::TX_START;
            end else begin
              tx_line <= 1'b1;
            end
          end
          uart_chan_pkg::TX_START: begin
            tx_line <= tx_shift[0];
            tx_shift <= {1'b1, tx_shift[7:1]};
            tx_bit <= 3'h0;
            tx_state <= uart_chan_pkg::TX_DATA;
          end
          uart_chan_pkg::TX_DATA: begin
            tx_bit <= tx_bit + 3'h1;
            tx_line <= (tx_bit == 3'h7) ? 1'b1 : tx_shift[0];
            tx_shift <= {1'b1, tx_shift[7:1]};
            tx_state <= (tx_bit == 3'h7) ? uart_chan_pkg::TX_STOP : uart_chan_pkg::TX_DATA;
          end
          uart_chan_pkg::TX_STOP: begin
            tx_line <= 1'b1;
            tx_state <= uart_chan_pkg::TX_IDLE;
          end
          default: begin
            tx_state <= uart_chan_pkg::TX_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Receiver
  // ****************************************************************
  uart_chan_pkg::rx_state_t rx_state;
  logic [3:0] rx_phase;
  logic [2:0] rx_bit;
  logic [7:0] rx_shift;
  logic [7:0] rx_word;
  logic rx_pending;
  wire rx_line = local_loop ? tx_line : line_in;
  wire rx_1x_level = rx_phase[3];
  wire rx_rise = ext_rx ? (ext_rx_clk && !ext_rx_d) : (baud_tick && (rx_phase == 4'h7));
  wire rx_reset = mreset || (wr_cmd && cmd == `UART_CMD_RESET_RX);
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire rx_full = !fifo_in_ready;
  wire rx_done = rx_rise && (rx_state == uart_chan_pkg::RX_STOP);

  // Start detection, mid-bit sampling and hand-off to the FIFO
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_state <= uart_chan_pkg::RX_IDLE;
      rx_phase <= 4'h0;
      rx_bit <= 3'h0;
      rx_shift <= `UART_RST_BYTE;
      rx_word <= `UART_RST_BYTE;
      rx_pending <= 1'b0;
    end else if (rx_reset) begin
      rx_state <= uart_chan_pkg::RX_IDLE;
      rx_pending <= 1'b0;
    end else begin
      if (rx_state == uart_chan_pkg::RX_IDLE) begin
        rx_phase <= 4'h0;
        if (rx_enable && !rx_line) begin
          rx_state <= uart_chan_pkg::RX_START;
        end
      end else begin
        rx_phase <= baud_tick ? rx_phase + 4'h1 : rx_phase;
        if (rx_rise) begin
          case (rx_state)
            uart_chan_pkg::RX_START: begin
              rx_bit <= 3'h0;
              rx_state <= rx_line ? uart_chan_pkg::RX_IDLE : uart_chan_pkg::RX_DATA;
            end
            uart_chan_pkg::RX_DATA: begin
              rx_shift <= {rx_line, rx_shift[7:1]};
              rx_bit <= rx_bit + 3'h1;
              rx_state <= (rx_bit == 3'h7) ? uart_chan_pkg::RX_STOP : uart_chan_pkg::RX_DATA;
            end
            uart_chan_pkg::RX_STOP: begin
              rx_state <= uart_chan_pkg::RX_IDLE;
            end
            default: begin
              rx_state <= uart_chan_pkg::RX_IDLE;
            end
          endcase
        end
      end
      if (rx_done) begin
        rx_word <= rx_shift;
        rx_pending <= 1'b1;
      end else if (fifo_in_ready) begin
        rx_pending <= 1'b0;
      end
    end
  end

  rx_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_flush(rx_reset),
    .i_in_valid(rx_pending),
    .o_in_ready(fifo_in_ready),
    .i_in_data(rx_word),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(rd_hold),
    .o_out_data(fifo_out_data)
  );

  // ****************************************************************
  // Control and status registers
  // ****************************************************************
  wire rx_flag = fifo_out_valid || rx_full;
  wire tx_ready = tx_enable && !tx_holding_full;
  wire tx_empty = tx_ready && tx_idle;
  wire rts_auto_drop = auto_rts && ((rx_full && rx_pending) || tx_done);
  wire [7:0] status = {1'b0, framing, 1'b0, overrun, tx_empty, tx_ready, rx_full, fifo_out_valid};
  wire [7:0] irq_status = {mpi0 != mpi0_d || input_delta, 3'h0, timer_out, 1'b0, rx_flag, tx_ready};
  wire [7:0] input_change = {3'h0, input_delta, 3'h0, mpi0};
  wire [7:0] input_port = {!irq_wire, 6'h00, mpi0};

  // Mode pointer, command actions, masks and sticky flags
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_reg_one <= `UART_RST_BYTE;
      mode_reg_two <= `UART_RST_BYTE;
      mode_ptr_two <= 1'b0;
      irq_mask_reg <= `UART_RST_BYTE;
      output_config_reg <= `UART_RST_OUTPUT_CFG;
      clock_select_reg <= 2'h0;
      timer_preset <= `UART_RST_BYTE;
      {rx_enable, tx_enable, rts_asserted, power_down} <= 4'h0;
      {overrun, framing, input_delta, timer_run} <= 4'h0;
    end else if (mreset) begin
      irq_mask_reg <= `UART_RST_BYTE;
      output_config_reg <= `UART_RST_OUTPUT_CFG;
      {overrun, framing, input_delta} <= 3'h0;
      {rx_enable, tx_enable, timer_run} <= 3'h0;
      mode_ptr_two <= 1'b0;
      power_down <= 1'b0;
      rts_asserted <= 1'b0;
    end else begin
      if (wr_mode) begin
        mode_ptr_two <= 1'b1;
        if (mode_ptr_two) begin
          mode_reg_two <= wdata;
        end else begin
          mode_reg_one <= wdata;
        end
      end else if (wr_cmd && cmd == `UART_CMD_RESET_POINTER) begin
        mode_ptr_two <= 1'b0;
      end
      if (wr_cmd) begin
        rx_enable <= (rx_enable || wdata[0]) && !wdata[1];
        tx_enable <= (tx_enable || wdata[2]) && !wdata[3];
        power_down <= (cmd == `UART_CMD_POWER_DOWN) || (power_down && cmd != `UART_CMD_POWER_UP);
      end
      if (wr_cmd && cmd == `UART_CMD_ASSERT_RTS) begin
        rts_asserted <= 1'b1;
      end else if ((wr_cmd && cmd == `UART_CMD_NEGATE_RTS) || rts_auto_drop) begin
        rts_asserted <= 1'b0;
      end
      if (wr_ev && addr == `UART_OFS_IRQ) begin
        irq_mask_reg <= wdata;
      end
      if (wr_ev && addr == `UART_OFS_OUTPUT_CFG) begin
        output_config_reg <= wdata[2:0];
      end
      if (wr_ev && addr == `UART_OFS_CLOCK_SEL) begin
        clock_select_reg <= wdata[1:0];
      end
      if (wr_ev && addr == `UART_OFS_TIMER) begin
        timer_preset <= wdata;
        timer_run <= 1'b1;
      end
      // Set wins over clear on every sticky flag
      overrun <= (rx_done && rx_pending && rx_full) || (overrun && !(wr_cmd && cmd == `UART_CMD_RESET_ERROR));
      framing <= (rx_done && !rx_line) || (framing && !(wr_cmd && cmd == `UART_CMD_RESET_ERROR));
      input_delta <= (mpi0 != mpi0_d) || (input_delta && !rd_input_change_reg);
    end
  end

  // ****************************************************************
  // Read data and pin outputs
  // ****************************************************************
  logic [7:0] rd_mux;
  always_comb begin
    case (addr)
      `UART_OFS_MODE: rd_mux = mode_ptr_two ? mode_reg_two : mode_reg_one;
      `UART_OFS_STATUS: rd_mux = status;
      `UART_OFS_HOLDING: rd_mux = fifo_out_data;
      `UART_OFS_INPUT_CHANGE: rd_mux = input_change;
      `UART_OFS_IRQ: rd_mux = irq_status;
      `UART_OFS_TIMER: rd_mux = timer_preset;
      `UART_OFS_OUTPUT_CFG: rd_mux = {5'h00, output_config_reg};
      `UART_OFS_INPUT_PORT: rd_mux = input_port;
      default: rd_mux = 8'h00;
    endcase
  end

  logic mpo_mux;
  always_comb begin
    case (uart_chan_pkg::mpo_func_t'(output_config_reg))
      uart_chan_pkg::MPO_RTS: mpo_mux = !rts_asserted;
      uart_chan_pkg::MPO_TIMER: mpo_mux = timer_out;
      uart_chan_pkg::MPO_TX_1X: mpo_mux = tx_1x_level;
      uart_chan_pkg::MPO_TX_16X: mpo_mux = clk16_level;
      uart_chan_pkg::MPO_RX_1X: mpo_mux = rx_1x_level;
      uart_chan_pkg::MPO_RX_16X: mpo_mux = clk16_level;
      uart_chan_pkg::MPO_TX_READY: mpo_mux = tx_ready;
      uart_chan_pkg::MPO_RX_FLAG: mpo_mux = rx_flag;
      default: mpo_mux = 1'b1;
    endcase
  end

  wire irq_active = |(irq_status & irq_mask_reg) && !mreset;

  // Registered pins; the bus follows chip select and read strobe
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_data <= 8'h00;
      o_data_oe <= 1'b0;
      o_interrupt_request_n <= 1'b0;
      o_interrupt_request_n_oe <= 1'b0;
      o_serial_out <= 1'b1;
      o_multi_output_pin <= 1'b1;
    end else begin
      o_data <= rd_ev ? rd_mux : o_data;
      o_data_oe <= !cs_n && !rd_n;
      o_interrupt_request_n <= 1'b0;
      o_interrupt_request_n_oe <= irq_active;
      o_serial_out <= mreset || local_loop || tx_line;
      o_multi_output_pin <= mpo_mux;
    end
  end
endmodule : uart_channel

`default_nettype wire

//--- verification/uart_channel_sva.sv
// Checker of the serial channel's pins.
// Assumes it is bound to uart_channel and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module uart_channel_chk (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_master_reset,
  input wire logic i_chip_select_n,
  input wire logic i_read_strobe_n,
  input wire logic [7:0] o_data,
  input wire logic o_data_oe,
  input wire logic o_interrupt_request_n,
  input wire logic o_interrupt_request_n_oe,
  input wire logic o_serial_out,
  input wire logic o_multi_output_pin
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  // Master reset held past its synchroniser
  sequence s_mreset_held;
    i_master_reset [*6];
  endsequence
  // Selected read strobe held low
  sequence s_read_held;
    (!i_chip_select_n && !i_read_strobe_n) [*5];
  endsequence
  a_line_marks: assert property (s_mreset_held |-> o_serial_out)
    else $error("serial line not marking under master reset");
  a_irq_dropped: assert property (s_mreset_held |-> !o_interrupt_request_n_oe)
    else $error("interrupt pulled under master reset");
  a_rts_negated: assert property (s_mreset_held |-> o_multi_output_pin)
    else $error("output pin not negated send request");
  a_irq_open_drain: assert property (!o_interrupt_request_n)
    else $error("interrupt output value not low");
  a_read_drives: assert property (s_read_held |-> o_data_oe)
    else $error("bus not driven during read");
  a_bus_released: assert property (i_chip_select_n [*5] |-> !o_data_oe)
    else $error("bus driven while deselected");
  a_drive_cause: assert property ($rose(o_data_oe) |-> $past(i_read_strobe_n, 2) == 1'h0)
    else $error("bus driven without read strobe");
  a_data_holds: assert property (i_read_strobe_n [*4] |=> $stable(o_data))
    else $error("read data changed without read");
endmodule : uart_channel_chk
bind uart_channel uart_channel_chk chk (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
  .i_master_reset(i_master_reset), .i_chip_select_n(i_chip_select_n), .i_read_strobe_n(i_read_strobe_n),
  .o_data(o_data), .o_data_oe(o_data_oe), .o_interrupt_request_n(o_interrupt_request_n),
  .o_interrupt_request_n_oe(o_interrupt_request_n_oe), .o_serial_out(o_serial_out),
  .o_multi_output_pin(o_multi_output_pin));
`default_nettype wire

//--- verification/remote_uart.sv
// Remote transceiver on the serial lines, 8 data bits, 1 stop.
// Assumes BIT clocks of i_clk per bit; idle line is high.
`timescale 1ns/1ns
`default_nettype none
module remote_uart #(parameter int BIT = 32) (
  input wire logic i_clk,
  input wire logic i_line,
  output logic o_line
);
  initial o_line = 1'h1;
  // Start, eight bits low first, stop
  task automatic send(input logic [7:0] b);
    for (int i = 0; i < 10; i++) begin
      o_line = (i == 0) ? 1'h0 : (i == 9) ? 1'h1 : b[i-1];
      repeat (BIT) @(negedge i_clk);
    end
  endtask : send
  // Bounded wait for start, then mid-bit samples
  task automatic recv(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    while (i_line && n < 8 * BIT) begin
      @(negedge i_clk);
      n++;
    end
    ok = !i_line;
    repeat (BIT / 2) @(negedge i_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(negedge i_clk);
      b[i] = i_line;
    end
  endtask : recv
endmodule : remote_uart
`default_nettype wire

//--- verification/tb_top.sv
// Bench of one serial channel: strobe-bus tasks and a remote transceiver.
// Assumes the design, checker and remote model are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_fail++; $display("BAD %0t %h %h", $time, (a), (e)); end end
module tb_top;
  localparam int BIT = 32;
  logic i_clk_sys = 0, i_arst_n = 0, i_master_reset = 0, cs_n = 1, wr_n = 1, rd_n = 1, mi0 = 1;
  logic [5:0] addr = 0;
  logic [7:0] wdata = 0, o_data, q;
  logic o_data_oe, irq_n, irq_oe, rxd, txd, mpo, ok;
  int n_fail = 0, comparisons = 0;
  logic [4:0] div = 0;
  always #5 i_clk_sys = ~i_clk_sys;
  // Free-running external transmit clock, one bit period long
  always @(negedge i_clk_sys) div <= div + 5'h01;
  uart_channel #(.BAUD_DIV(2), .FIFO_DEPTH(8)) dut (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
    .i_master_reset(i_master_reset), .i_chip_select_n(cs_n), .i_write_strobe_n(wr_n), .i_read_strobe_n(rd_n),
    .i_addr(addr), .i_data(wdata), .o_data(o_data), .o_data_oe(o_data_oe), .i_interrupt_request_n(!irq_oe),
    .o_interrupt_request_n(irq_n), .o_interrupt_request_n_oe(irq_oe), .i_serial_in(rxd), .o_serial_out(txd),
    .i_ext_rx_clock(1'h0), .i_ext_tx_clock(div[4]), .i_multi_input_zero(mi0), .o_multi_output_pin(mpo));
  remote_uart #(.BIT(BIT)) far (.i_clk(i_clk_sys), .i_line(txd), .o_line(rxd));
  // One strobe cycle; q takes the read data while the strobe is low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
    cs_n = 1'h0;
    addr = a;
    wdata = d;
    repeat (5) @(negedge i_clk_sys);
    wr_n = !wr;
    rd_n = wr;
    repeat (6) @(negedge i_clk_sys);
    q = o_data;
    wr_n = 1'h1;
    rd_n = 1'h1;
    repeat (6) @(negedge i_clk_sys);
    cs_n = 1'h1;
    repeat (5) @(negedge i_clk_sys);
  endtask : bus
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  // Main sequence
  initial begin
    repeat (12) @(negedge i_clk_sys);
    i_arst_n = 1'h1;
    repeat (6) @(negedge i_clk_sys);
    `CHK(txd, 1'h1)
    for (int k = 0; k < 2; k++) begin
      bus(1, 6'h02, k ? 8'h90 : 8'h80);
      `CHK(mpo, k[0])
    end
    mi0 = 1'h0;
    repeat (4) @(negedge i_clk_sys);
    bus(0, 6'h08, 8'h00);
    `CHK(q[0], 1'h0)
    bus(0, 6'h04, 8'h00);
    `CHK({q[4], q[0]}, 2'h2)
    bus(1, 6'h00, 8'h80);
    bus(1, 6'h02, 8'h81);
    `CHK(mpo, 1'h0)
    for (int k = 0; k < 9; k++) far.send(8'h31 + k[7:0]);
    `CHK(mpo, 1'h1)
    bus(0, 6'h01, 8'h00);
    `CHK(q[1], 1'h1)
    for (int k = 0; k < 9; k++) begin
      bus(0, 6'h03, 8'h00);
      `CHK(q, 8'h31 + k[7:0])
    end
    mi0 = 1'h1;
    bus(1, 6'h00, 8'h10);
    bus(1, 6'h02, 8'h04);
    bus(1, 6'h03, 8'ha6);
    repeat (3 * BIT) @(negedge i_clk_sys);
    `CHK(txd, 1'h1)
    mi0 = 1'h0;
    far.recv(q, ok);
    `CHK({ok, q}, 9'h1a6)
    if (!ok) summarize;
    // Second character on the external transmit clock
    bus(1, 6'h09, 8'h02);
    bus(1, 6'h03, 8'h5c);
    far.recv(q, ok);
    `CHK({ok, q}, 9'h15c)
    // Unmask the sticky input change; line pulled and seen on bit 7
    bus(1, 6'h05, 8'h80);
    `CHK(irq_oe, 1'h1)
    bus(0, 6'h08, 8'h00);
    `CHK(q[7], 1'h1)
    // Let the stop bit finish so auto negation is past, then assert
    repeat (2 * BIT) @(negedge i_clk_sys);
    bus(1, 6'h02, 8'h80);
    `CHK(mpo, 1'h0)
    i_master_reset = 1'h1;
    repeat (10) @(negedge i_clk_sys);
    i_master_reset = 1'h0;
    repeat (6) @(negedge i_clk_sys);
    `CHK({mpo, txd}, 2'h3)
    `CHK(irq_oe, 1'h0)
    bus(0, 6'h01, 8'h00);
    `CHK(q, 8'h00)
    bus(0, 6'h00, 8'h00);
    `CHK(q, 8'h80)
    summarize;
  end
endmodule : tb_top
`default_nettype wire
